// File: pkg/tmr_out_consts.vh
// constants for the timer output recovery block
`ifndef TMR_OUT_CONSTS_VH
`define TMR_OUT_CONSTS_VH

// address map: region in paddr[7:5], channel index in paddr[4:2]
`define RGN_GLOBAL 3'h0
`define RGN_MODE 3'h1
`define RGN_IOCTL 3'h2
`define RGN_CMPA 3'h3
`define RGN_CMPB 3'h4
`define RGN_CNT 3'h5
`define ADDR_START 8'h00
`define ADDR_OUTEN 8'h04
`define ADDR_OUTCTL 8'h08
`define ADDR_PINSTAT 8'h0c

// channel count and index limits
`define NUM_CH 5
`define CH_LAST 3'h4
`define CH_PAIR_LO 3'h3
`define CH_PAIR_HI 3'h4

// mode codes
`define MODE_NORMAL 3'h0
`define MODE_PWM1 3'h1
`define MODE_PWM2 3'h2
`define MODE_PHASE 3'h3
`define MODE_RPWM 3'h4
`define MODE_CPWM 3'h5

// pin action codes on compare match
`define ACT_OFF 2'h0
`define ACT_LOW 2'h1
`define ACT_HIGH 2'h2
`define ACT_TOGGLE 2'h3

// pin I/O control field positions
`define IO_ACTA_LSB 0
`define IO_INITA 2
`define IO_ACTB_LSB 4
`define IO_INITB 6
`define IO_WIDTH 7

// output level control fields
`define OC_CYCLIC 0
`define OC_LEVEL 1

// output master enable fields
`define OE_CH3 0
`define OE_CH4 1

// reset values
`define RST_MODE 3'h0
`define RST_IOCTL 7'h00
`define RST_CMP 16'hffff
`define RST_OUTCTL 2'h0
`define RST_OUTEN 2'h0

`endif

// File: hw/tmr_chan_counter.v
// one channel counter with two compare matches
`timescale 1ns/1ps
module tmr_chan_counter (
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // control
    input wire run,
    input wire clrOnA,
    input wire [15:0] cmpA,
    input wire [15:0] cmpB,
    // state
    output wire [15:0] cnt,
    output wire matchA,
    output wire matchB
);
    reg [15:0] cnt_q; // running count
    assign cnt = cnt_q;
    // matches only count while running, so a stopped channel never fires
    assign matchA = run && (cnt_q == cmpA);
    assign matchB = run && (cnt_q == cmpB);

    // count up; clear on match A where it is the cycle register
    always @(posedge clk_sys) begin
        if (!nrst) begin
            cnt_q <= 16'h0000;
        end else if (run) begin
            if (clrOnA && matchA) begin
                cnt_q <= 16'h0000;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end
endmodule // tmr_chan_counter

// File: hw/timer_output_mode_recovery.v
// timer output stage: modes, pin init, stop and mode-change levels
//
// How it works
// R01 - after reset all timer outputs low
// R02 - PWM1 io write skips channel B pin
// R03 - PWM2 io write skips cycle register pin
// R04 - PWM2 only legal on channels 0 to 2
// R05 - phase counting only on channels 1, 2
// R06 - complementary PWM waveform from compare matches
// R07 - complementary stop restores initial output value
// R08 - complementary to normal drives outputs low
// R09 - compare match applies configured pin action
// R10 - start bit runs, cleared bit stops counter
// R11 - software parks pin on port before stopping
// R12 - io write sets initial pin levels
// R13 - io control can disable waveform generation
// R14 - master enable gates channel 3/4 outputs
// R15 - output control sets level and cyclic output
// R16 - software follows ordered complementary entry sequence
// R17 - same-mode restart skips mode write only
// R18 - enable channel 3/4 before pin init
// R19 - external load treats low as active
// R20 - port selection freezes waveform-driven pin state; in pair modes channel 4 pins follow pinFuncTimer[3]
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "tmr_out_consts.vh"
module timer_output_mode_recovery (
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // apb slave
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // pin function controller: high selects timer output per channel
    input wire [4:0] pinFuncTimer,
    // timer outputs toward the pin multiplexer
    output reg [4:0] timerOutA,
    output reg [4:0] timerOutB,
    output reg cycleOut
);
    // register state
    reg [4:0] start_q; // counter_start_register
    reg [1:0] outEn_q; // output_master_enable_register
    reg [1:0] outCtl_q; // output_level_control_register
    reg [2:0] mode_q [0:4]; // per-channel mode
    reg [6:0] ioCtl_q [0:4]; // pin_io_control_register per channel
    reg [15:0] cmpA_q [0:4]; // compare A, cycle in pwm modes
    reg [15:0] cmpB_q [0:4]; // compare B, duty in pwm modes
    reg [4:0] pinA_q; // internal channel_a_compare_pin state
    reg [4:0] pinB_q; // internal channel_b_compare_pin state
    reg pos3_q; // positive phase, pair output 3
    reg pos4_q; // positive phase, pair output 4
    reg cyc_q; // cyclic output state
    integer i;

    // counter buses
    wire [79:0] cntBus;
    wire [4:0] matchA;
    wire [4:0] matchB;
    wire [4:0] clrOnA;

    // apb decode
    wire setup = psel && !penable && !pready;
    wire [2:0] rgn = paddr[7:5];
    wire [2:0] chIdx = paddr[4:2];
    wire chOk = (chIdx <= `CH_LAST);
    wire globOk = (paddr == `ADDR_START) || (paddr == `ADDR_OUTEN) ||
                  (paddr == `ADDR_OUTCTL) || (paddr == `ADDR_PINSTAT);
    wire mapped = (rgn == `RGN_GLOBAL) ? globOk :
                  ((rgn <= `RGN_CNT) && chOk);
    // writes land at the edge that ends the access cycle, with pready high
    wire wrEn = psel && penable && pready && pwrite && mapped;

    // pair modes belong to channel 3 and drive channels 3 and 4
    wire pairMode = (mode_q[3] == `MODE_CPWM) || (mode_q[3] == `MODE_RPWM);
    wire [15:0] cnt3 = cntBus[63:48];

    // mode legality per channel
    function legalMode;
        input [2:0] ch;
        input [2:0] m;
        input [1:0] oe;
        begin
            case (m)
                `MODE_NORMAL, `MODE_PWM1: legalMode = 1'b1;
                `MODE_PWM2: legalMode = (ch <= 3'h2); // R04
                `MODE_PHASE: legalMode = (ch == 3'h1) || (ch == 3'h2); // R05
                // pair modes need outputs off first
                `MODE_CPWM, `MODE_RPWM: legalMode = (ch == `CH_PAIR_LO) && (oe == 2'h0); // R14
                default: legalMode = 1'b0;
            endcase
        end
    endfunction

    // pin level after a compare match
    function applyAct;
        input cur;
        input [1:0] act;
        begin
            case (act)
                `ACT_LOW: applyAct = 1'b0;
                `ACT_HIGH: applyAct = 1'b1;
                `ACT_TOGGLE: applyAct = ~cur;
                default: applyAct = cur; // generation disabled
            endcase
        end
    endfunction

    // counters, one per channel
    genvar g;
    generate
        for (g = 0; g < `NUM_CH; g = g + 1) begin : gCh
            // in pwm modes compare A is the cycle register
            assign clrOnA[g] = (mode_q[g] != `MODE_NORMAL) && (mode_q[g] != `MODE_PHASE);
            tmr_chan_counter uCnt (
                .clk_sys(clk_sys),
                .nrst(nrst),
                .run(start_q[g]), // R10
                .clrOnA(clrOnA[g]),
                .cmpA(cmpA_q[g]),
                .cmpB(cmpB_q[g]),
                .cnt(cntBus[16*g+15:16*g]),
                .matchA(matchA[g]),
                .matchB(matchB[g])
            );
        end
    endgenerate

    // apb answer: ready in the first access cycle
    always @(posedge clk_sys) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            if (setup && !pwrite) begin
                prdata <= 32'h00000000;
                // unmapped reads return zero
                if (mapped) begin
                    case (rgn)
                        `RGN_GLOBAL: begin
                            if (paddr == `ADDR_START) begin
                                prdata <= {27'h0000000, start_q};
                            end else if (paddr == `ADDR_OUTEN) begin
                                prdata <= {30'h00000000, outEn_q};
                            end else if (paddr == `ADDR_OUTCTL) begin
                                prdata <= {30'h00000000, outCtl_q};
                            end else begin
                                // live internal pin state
                                prdata <= {21'h000000, cyc_q, pinB_q, pinA_q};
                            end
                        end
                        `RGN_MODE: prdata <= {29'h00000000, mode_q[chIdx]};
                        `RGN_IOCTL: prdata <= {25'h0000000, ioCtl_q[chIdx]};
                        `RGN_CMPA: prdata <= {16'h0000, cmpA_q[chIdx]};
                        `RGN_CMPB: prdata <= {16'h0000, cmpB_q[chIdx]};
                        `RGN_CNT: prdata <= {16'h0000, cntBus[16*chIdx +: 16]};
                        default: prdata <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    // register writes and internal pin state
    always @(posedge clk_sys) begin
        if (!nrst) begin
            start_q <= 5'h00;
            outEn_q <= `RST_OUTEN;
            outCtl_q <= `RST_OUTCTL;
            pinA_q <= 5'h00; // R01
            pinB_q <= 5'h00; // R01
            pos3_q <= 1'b0;
            pos4_q <= 1'b0;
            cyc_q <= 1'b0;
            for (i = 0; i < `NUM_CH; i = i + 1) begin
                mode_q[i] <= `RST_MODE;
                ioCtl_q[i] <= `RST_IOCTL;
                cmpA_q[i] <= `RST_CMP;
                cmpB_q[i] <= `RST_CMP;
            end
        end else begin
            // waveform events; frozen while the port owns the pin
            for (i = 0; i < `NUM_CH; i = i + 1) begin
                if (pinFuncTimer[i]) begin // R20
                    case (mode_q[i])
                        `MODE_NORMAL, `MODE_PHASE: begin
                            if (matchA[i]) begin
                                pinA_q[i] <= applyAct(pinA_q[i], ioCtl_q[i][1:0]); // R09
                            end
                            if (matchB[i]) begin
                                pinB_q[i] <= applyAct(pinB_q[i], ioCtl_q[i][5:4]); // R09
                            end
                        end
                        `MODE_PWM1: begin
                            // both matches steer pin A; pin B carries no wave
                            if (matchB[i]) begin
                                pinA_q[i] <= applyAct(pinA_q[i], ioCtl_q[i][5:4]); // R09
                            end else if (matchA[i]) begin
                                pinA_q[i] <= applyAct(pinA_q[i], ioCtl_q[i][1:0]); // R09
                            end
                        end
                        `MODE_PWM2: begin
                            // cycle end restores pin B, duty match applies action
                            if (matchA[i] && ioCtl_q[i][5:4] != `ACT_OFF) begin
                                pinB_q[i] <= ioCtl_q[i][`IO_INITB];
                            end else if (matchB[i]) begin
                                pinB_q[i] <= applyAct(pinB_q[i], ioCtl_q[i][5:4]); // R09
                            end
                        end
                        default: begin
                            // pair modes handled below
                        end
                    endcase
                end
            end

            // complementary and reset-synchronized pair waveform
            if (pairMode && start_q[3] && pinFuncTimer[3]) begin
                if (matchA[3]) begin
                    pos3_q <= 1'b0; // R06
                    pos4_q <= 1'b0;
                    if (outCtl_q[`OC_CYCLIC]) begin
                        cyc_q <= ~cyc_q; // R15
                    end
                end else begin
                    if (cnt3 == cmpB_q[3]) begin
                        pos3_q <= 1'b1; // R06
                    end
                    if (cnt3 == cmpB_q[4]) begin
                        pos4_q <= 1'b1; // R06
                    end
                end
            end
            if (pairMode) begin
                // positive phases on A pins, negative on B pins
                pinA_q[3] <= pos3_q ^ outCtl_q[`OC_LEVEL]; // R06
                pinB_q[3] <= ~pos3_q ^ outCtl_q[`OC_LEVEL];
                pinA_q[4] <= pos4_q ^ outCtl_q[`OC_LEVEL];
                pinB_q[4] <= ~pos4_q ^ outCtl_q[`OC_LEVEL];
            end

            // software writes take effect last and win
            if (wrEn) begin
                case (rgn)
                    `RGN_GLOBAL: begin
                        if (paddr == `ADDR_START) begin
                            start_q <= pwdata[4:0]; // R10
                            if (pairMode && start_q[3] && !pwdata[3]) begin
                                // stop returns pair to its initial value
                                pos3_q <= 1'b0; // R07
                                pos4_q <= 1'b0; // R07
                            end
                        end else if (paddr == `ADDR_OUTEN) begin
                            outEn_q <= pwdata[1:0]; // R14
                        end else if (paddr == `ADDR_OUTCTL) begin
                            // level may only change with pair outputs off
                            if (outEn_q == 2'h0) begin
                                outCtl_q <= pwdata[1:0]; // R15
                            end
                        end
                    end
                    `RGN_MODE: begin
                        if (legalMode(chIdx, pwdata[2:0], outEn_q)) begin // R04 R05
                            mode_q[chIdx] <= pwdata[2:0];
                            if (chIdx == `CH_PAIR_LO) begin
                                if ((pwdata[2:0] == `MODE_CPWM) ||
                                    (pwdata[2:0] == `MODE_RPWM)) begin
                                    // entering a pair mode: cyclic pin low
                                    cyc_q <= 1'b0; // R15
                                    pos3_q <= 1'b0;
                                    pos4_q <= 1'b0;
                                end else if (mode_q[3] == `MODE_CPWM) begin
                                    pinA_q[4:3] <= 2'h0; // R08
                                    pinB_q[4:3] <= 2'h0; // R08
                                end else if (mode_q[3] == `MODE_RPWM) begin
                                    // positive low, negative high
                                    pinA_q[4:3] <= 2'h0;
                                    pinB_q[4:3] <= 2'h3;
                                end
                            end
                        end
                    end
                    `RGN_IOCTL: begin
                        ioCtl_q[chIdx] <= pwdata[`IO_WIDTH-1:0];
                        // pair-owned channels keep their levels
                        if (!(pairMode && chIdx >= `CH_PAIR_LO)) begin
                            // an off action leaves the pin and stops generation
                            if (pwdata[1:0] != `ACT_OFF &&
                                mode_q[chIdx] != `MODE_PWM2) begin // R03 R13
                                pinA_q[chIdx] <= pwdata[`IO_INITA]; // R12
                            end
                            if (pwdata[5:4] != `ACT_OFF &&
                                mode_q[chIdx] != `MODE_PWM1) begin // R02 R13
                                pinB_q[chIdx] <= pwdata[`IO_INITB]; // R12
                            end
                        end
                    end
                    `RGN_CMPA: cmpA_q[chIdx] <= pwdata[15:0];
                    `RGN_CMPB: cmpB_q[chIdx] <= pwdata[15:0];
                    default: begin
                        // counters are read only
                    end
                endcase
            end
        end
    end

    // registered outputs; channels 3 and 4 gated by master enable
    always @(posedge clk_sys) begin
        if (!nrst) begin
            timerOutA <= 5'h00; // R01
            timerOutB <= 5'h00; // R01
            cycleOut <= 1'b0;
        end else begin
            timerOutA <= pinA_q & {outEn_q[`OE_CH4], outEn_q[`OE_CH3], 3'h7}; // R14
            timerOutB <= pinB_q & {outEn_q[`OE_CH4], outEn_q[`OE_CH3], 3'h7}; // R14
            cycleOut <= cyc_q & pairMode;
        end
    end
endmodule // timer_output_mode_recovery

// File: testbench/timer_output_mode_recovery_props.sv
// assertion checker for the timer output recovery block
`timescale 1ns/1ps
`include "tmr_out_consts.vh"
module timer_output_mode_recovery_props (
    // clock and reset
    input logic clk_sys,
    input logic nrst,
    // apb slave side
    input logic [7:0] paddr,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    // pin multiplexer and timer outputs
    input logic [4:0] pinFuncTimer,
    input logic [4:0] timerOutA,
    input logic [4:0] timerOutB,
    input logic cycleOut
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic [1:0] outEn_q; // shadow of the master enable bits
    logic level_q; // shadow of the pair output level
    logic cpwm_q; // channel 3 sits in complementary mode
    wire wrDone = psel && penable && pready && pwrite;
    wire [7:0] modeAddr = {`RGN_MODE, `CH_PAIR_LO, 2'b00};
    // shadow state; level writes are dropped while outputs enabled, as in the block
    always @(posedge clk_sys) begin
        if (!nrst) begin
            outEn_q <= `RST_OUTEN;
            level_q <= 1'b0;
            cpwm_q <= 1'b0;
        end else if (wrDone) begin
            if (paddr == `ADDR_OUTEN) outEn_q <= pwdata[1:0];
            if (paddr == `ADDR_OUTCTL && outEn_q == 2'h0) level_q <= pwdata[`OC_LEVEL];
            if (paddr == modeAddr && (pwdata[2:0] != `MODE_CPWM || outEn_q == 2'h0))
                cpwm_q <= (pwdata[2:0] == `MODE_CPWM);
        end
    end
    // stop and leave writes on the complementary pair
    sequence pairStop;
        wrDone && paddr == `ADDR_START && !pwdata[3] && cpwm_q && outEn_q == 2'h3;
    endsequence
    sequence pairLeave;
        wrDone && paddr == modeAddr && pwdata[2:0] == `MODE_NORMAL && cpwm_q;
    endsequence
    a_reset_outputs_low: assert property (disable iff (1'b0) !nrst |=>
        timerOutA == 5'h00 && timerOutB == 5'h00 && !cycleOut && !pready)
        else $error("outputs not low after reset");
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready in the access cycle");
    a_ready_one_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_error_reads_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
        else $error("error answer without ready or with data");
    a_pair_gated_off: assert property ((outEn_q == 2'h0) [*3] |->
        timerOutA[4:3] == 2'h0 && timerOutB[4:3] == 2'h0)
        else $error("pair outputs driven while disabled");
    a_port_freezes_pin: assert property ((!pinFuncTimer[1] && !psel) [*3] |->
        $stable(timerOutA[1]) && $stable(timerOutB[1]))
        else $error("pin moved while port selected");
    a_pair_complement: assert property ((cpwm_q && outEn_q == 2'h3) [*3] |->
        timerOutB[4:3] == ~timerOutA[4:3])
        else $error("pair outputs not complementary");
    a_pair_stop_level: assert property (pairStop |-> ##3
        timerOutA[3] == level_q && timerOutB[3] == !level_q)
        else $error("stop did not restore pair level");
    a_pair_leave_low: assert property (pairLeave |-> ##2
        timerOutA[4:3] == 2'h0 && timerOutB[4:3] == 2'h0)
        else $error("leaving pair mode left outputs high");
endmodule // timer_output_mode_recovery_props

// File: testbench/pin_load_model.sv
// external load as seen through the pin multiplexer
`timescale 1ns/1ps
module pin_load_model (
    // timer side and multiplexer select
    input logic [4:0] timerOutA,
    input logic [4:0] timerOutB,
    input logic [4:0] pinFuncTimer,
    // pin levels at the load
    output logic [4:0] pinA,
    output logic [4:0] pinB
);
    // port side parks pins at the inactive level; low is active at the load
    assign pinA = (pinFuncTimer & timerOutA) | ~pinFuncTimer;
    assign pinB = (pinFuncTimer & timerOutB) | ~pinFuncTimer;
endmodule // pin_load_model

// File: testbench/timer_output_mode_recovery_bench.sv
// self-checking bench for the timer output recovery block
`timescale 1ns/1ps
`include "tmr_out_consts.vh"
module timer_output_mode_recovery_bench;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [4:0] pinFuncTimer = 5'h00;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire cycleOut;
    wire [4:0] timerOutA;
    wire [4:0] timerOutB;
    wire [4:0] pinA;
    wire [4:0] pinB;
    int num_errors = 0;
    int num_checks = 0;
    int seed = 68; // fixed seed for compare values
    int toggles;
    logic [32:0] expQ[$]; // expected {error, data} of each read
    int cycT; // cyclic output toggles
    logic prevC;
    logic [2:0] m;
    logic prevA;
    timer_output_mode_recovery dut (.clk_sys(clk_sys), .nrst(nrst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pinFuncTimer(pinFuncTimer),
        .timerOutA(timerOutA), .timerOutB(timerOutB), .cycleOut(cycleOut));
    pin_load_model load (.timerOutA(timerOutA), .timerOutB(timerOutB),
        .pinFuncTimer(pinFuncTimer), .pinA(pinA), .pinB(pinB));
    // free-running 200 MHz clock
    initial forever #2.5 clk_sys = ~clk_sys;
    // one comparison
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until ready; reads queue their expected answer
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
        input logic [32:0] e);
        int n;
        n = 0;
        if (!w) expQ.push_back(e);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge clk_sys);
        end
        if (n == 16) begin
            num_errors++;
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 33'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b0, 32'h0, {1'b0, d});
    endtask
    // per-channel register address
    function automatic logic [7:0] ra(input logic [2:0] r, input logic [2:0] c);
        return {r, c, 2'b00};
    endfunction
    // answer watcher: oldest note against each completed read
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (expQ.size() == 0) num_errors++;
            else chk({pslverr, prdata}, expQ.pop_front());
        end
    end
    // verdict, reached from the main sequence and from the watchdog
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int c = 0; c < 5; c++) begin
            rd(ra(`RGN_MODE, c[2:0]), {29'h0, `RST_MODE});
            rd(ra(`RGN_CMPA, c[2:0]), {16'h0, `RST_CMP});
        end
        rd(`ADDR_PINSTAT, 32'h0);
        apb(8'hc0, 1'b0, 32'h0, {1'b1, 32'h0});
        $display("test reset done");
        // mode legality per channel; refused writes leave the old mode
        for (int c = 0; c < 5; c++) begin
            wr(ra(`RGN_MODE, c[2:0]), {29'h0, `MODE_PWM2});
            m = (c <= 2) ? `MODE_PWM2 : `MODE_NORMAL;
            rd(ra(`RGN_MODE, c[2:0]), {29'h0, m});
            wr(ra(`RGN_MODE, c[2:0]), {29'h0, `MODE_PHASE});
            if (c == 1 || c == 2) m = `MODE_PHASE;
            rd(ra(`RGN_MODE, c[2:0]), {29'h0, m});
            wr(ra(`RGN_MODE, c[2:0]), {29'h0, `MODE_NORMAL});
        end
        $display("test legality done");
        // normal mode on channel 0: init high, low on match, recovery
        wr(ra(`RGN_IOCTL, 3'h0), 32'h05);
        rd(`ADDR_PINSTAT, 32'h001);
        wr(ra(`RGN_CMPA, 3'h0), {16'h0, 16'h0010 + 16'($random(seed) & 15)});
        pinFuncTimer <= 5'h01;
        wr(`ADDR_START, 32'h01);
        repeat (40) @(posedge clk_sys);
        rd(`ADDR_PINSTAT, 32'h000);
        pinFuncTimer <= 5'h00;
        wr(`ADDR_START, 32'h00);
        chk({32'h0, pinA[0]}, 33'h1);
        wr(ra(`RGN_IOCTL, 3'h0), 32'h05);
        rd(`ADDR_PINSTAT, 32'h001);
        $display("test normal done");
        // pwm 1 on channel 1: pin B untouched, frozen while on port
        wr(ra(`RGN_IOCTL, 3'h1), 32'h50);
        rd(`ADDR_PINSTAT, 32'h041);
        wr(ra(`RGN_MODE, 3'h1), {29'h0, `MODE_PWM1});
        wr(ra(`RGN_IOCTL, 3'h1), 32'h25);
        rd(`ADDR_PINSTAT, 32'h043);
        wr(ra(`RGN_CMPA, 3'h1), {16'h0, 16'h0008 + 16'($random(seed) & 7)});
        wr(`ADDR_START, 32'h02);
        repeat (40) @(posedge clk_sys);
        rd(`ADDR_PINSTAT, 32'h043);
        pinFuncTimer <= 5'h02;
        repeat (40) @(posedge clk_sys);
        rd(`ADDR_PINSTAT, 32'h041);
        wr(ra(`RGN_IOCTL, 3'h1), 32'h04);
        repeat (40) @(posedge clk_sys);
        rd(`ADDR_PINSTAT, 32'h041);
        pinFuncTimer <= 5'h00;
        wr(`ADDR_START, 32'h00);
        $display("test pwm1 done");
        // pwm 2 on channel 2: cycle register pin A not initialised
        wr(ra(`RGN_MODE, 3'h2), {29'h0, `MODE_PWM2});
        wr(ra(`RGN_IOCTL, 3'h2), 32'h55);
        rd(`ADDR_PINSTAT, 32'h0c1);
        $display("test pwm2 done");
        // complementary pair: ordered entry, run, stop, leave
        wr(`ADDR_OUTCTL, 32'h03);
        rd(`ADDR_OUTCTL, 32'h03);
        wr(ra(`RGN_MODE, `CH_PAIR_LO), {29'h0, `MODE_CPWM});
        rd(ra(`RGN_MODE, `CH_PAIR_LO), {29'h0, `MODE_CPWM});
        wr(`ADDR_OUTEN, 32'h03);
        wr(`ADDR_OUTCTL, 32'h00);
        rd(`ADDR_OUTCTL, 32'h03);
        wr(ra(`RGN_CMPA, `CH_PAIR_LO), 32'h20);
        wr(ra(`RGN_CMPB, `CH_PAIR_LO), 32'h10);
        wr(ra(`RGN_CMPB, `CH_PAIR_HI), 32'h18);
        pinFuncTimer <= 5'h18;
        wr(`ADDR_START, 32'h08);
        toggles = 0;
        prevA = timerOutA[3];
        cycT = 0;
        prevC = cycleOut;
        repeat (100) begin
            @(posedge clk_sys);
            if (timerOutA[3] !== prevA) toggles++;
            prevA = timerOutA[3];
            if (cycleOut !== prevC) cycT++;
            prevC = cycleOut;
        end
        chk({32'h0, toggles != 0}, 33'h1);
        chk({32'h0, cycT != 0}, 33'h1);
        pinFuncTimer <= 5'h00;
        wr(`ADDR_START, 32'h00);
        repeat (3) @(posedge clk_sys);
        chk({29'h0, timerOutA[4:3], timerOutB[4:3]}, 33'hc);
        wr(ra(`RGN_MODE, `CH_PAIR_LO), {29'h0, `MODE_NORMAL});
        repeat (2) @(posedge clk_sys);
        chk({29'h0, timerOutA[4:3], timerOutB[4:3]}, 33'h0);
        // outputs already enabled, so the pin init shows at once
        wr(ra(`RGN_IOCTL, `CH_PAIR_LO), 32'h55);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, timerOutA[3], timerOutB[3]}, 33'h3);
        $display("test pair done");
        repeat (4) @(posedge clk_sys);
        complete_run();
    end
endmodule // timer_output_mode_recovery_bench
bind timer_output_mode_recovery timer_output_mode_recovery_props props (.clk_sys(clk_sys),
    .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pinFuncTimer(pinFuncTimer), .timerOutA(timerOutA), .timerOutB(timerOutB),
    .cycleOut(cycleOut));
